// ### rtl/sarcp_pkg.sv
// package for the sar converter serial conversion port
// assumes a 100 MHz core clock; all pin timing is counted in its cycles
package sarcp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // conversion length bounds in ns, and derived cycle counts
    localparam int CONV_MIN_NS = 500;
    localparam int CONV_MAX_NS = 1300;
    localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int CONV_SPAN_CYC = CONV_MAX_CYC - CONV_MIN_CYC;
    // output timing bounds in ns (not met: synchronisers and the output flop add three clocks of latency)
    localparam real DATA_DLY_NS = 13.4;
    localparam real EN_DLY_NS = 12.3;
    localparam real HZ_DLY_NS = 13.2;
    localparam int RES_W = 16;
    localparam int BIT_CNT_W = 5;
    localparam int CYC_CNT_W = 8;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h10;
    localparam logic [CYC_CNT_W-1:0] CYC_RST = 8'h00;
    localparam logic [7:0] LFSR_SEED = 8'hA5;
    localparam logic [RES_W-1:0] RES_RST = 16'h0000;

    typedef enum logic [1:0] {
        SARCP_ACQ = 2'b00,
        SARCP_CONV = 2'b01
    } sarcp_state_t;

    // pins from the host, grouped
    typedef struct packed {
        logic conv_trig;
        logic mode_sel;
        logic sclk;
    } sarcp_host_pins_t;

    // sampled analog inputs, digital stand-ins for the two input pins
    typedef struct packed {
        logic signed [RES_W-1:0] pos;
        logic signed [RES_W-1:0] neg;
    } sarcp_analog_t;
endpackage

// ### rtl/sarcp_port.sv
// serial conversion port of a 16-bit sar converter: sequencing and readout
// assumes host pins are asynchronous to clk_i and synchronised here
// Overview of operation
// - conversion start samples input difference
// - inputs disconnected during whole conversion
// - conversion timed by internal clock
// - reconnect inputs then enter acquisition
// - power down after conversion, through acquisition
// - result read during following acquisition
// - mode chosen from mode_sel at start
// - 3-wire: trigger low is chip select
// - 4-wire: mode_sel low is chip select
// - shift out after each sclk falling edge
// - 3-wire: msb driven on trigger fall
// - 3-wire: float on trigger rise/last edge
// - 4-wire: msb driven on mode_sel fall
// - 4-wire: float on mode_sel rise/last edge
// - daisy: mode_sel shifted in on falls
// - conversion 500 to 1300 ns, varying
// - result is two's complement difference
// - 16 bits msb first, float after 16th
module sarcp_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // host pins
    input wire sarcp_pkg::sarcp_host_pins_t pins_i,
    // analog stand-ins
    input wire sarcp_pkg::sarcp_analog_t analog_i,
    // serial output, two signals of a three-state pin
    output logic sdo_o,
    output logic sdo_oe_o,
    // analog and power control, busy and mode status
    output logic inputs_conn_o,
    output logic powered_o,
    output logic converting_o,
    output logic daisy_mode_o
);
    import sarcp_pkg::*;

    logic rst_s1_ff, rst_b_ff;
    logic [2:0] sync1_ff, sync2_ff, prev_ff;
    logic trig, msel, sclk, trig_rise, trig_fall, msel_rise, msel_fall, sclk_fall;
    sarcp_state_t state_ff, nxt_state;
    logic [CYC_CNT_W-1:0] cyc_ff, nxt_cyc, len_ff, nxt_len;
    logic [7:0] lfsr_ff, nxt_lfsr;
    logic [RES_W-1:0] samp_ff, nxt_samp, sh_ff, nxt_sh;
    logic [BIT_CNT_W-1:0] bit_ff, nxt_bit;
    logic daisy_ff, nxt_daisy, oe_ff, nxt_oe, do_ff, nxt_do;
    logic conn_ff, nxt_conn, pwr_ff, nxt_pwr;
    logic conv_ff, nxt_conv;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_b_ff <= rst_s1_ff;
        end
    end

    // two-flop synchronisers, then a history flop for edge finding
    always_ff @(posedge clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff <= 3'h0;
        end else begin
            sync1_ff <= {pins_i.conv_trig, pins_i.mode_sel, pins_i.sclk};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign trig = sync2_ff[2];
    assign msel = sync2_ff[1];
    assign sclk = sync2_ff[0];
    assign trig_rise = trig & ~prev_ff[2];
    assign trig_fall = ~trig & prev_ff[2];
    assign msel_rise = msel & ~prev_ff[1];
    assign msel_fall = ~msel & prev_ff[1];
    assign sclk_fall = ~sclk & prev_ff[0];

    // sequencer: conversion timing, sampling, mode capture, power
    always_comb begin
        nxt_state = state_ff;
        nxt_cyc = cyc_ff;
        nxt_len = len_ff;
        nxt_lfsr = lfsr_ff;
        nxt_samp = samp_ff;
        nxt_daisy = daisy_ff;
        nxt_conn = conn_ff;
        nxt_pwr = pwr_ff;
        unique case (state_ff)
            SARCP_ACQ: begin
                if (trig_rise) begin
                    nxt_state = SARCP_CONV;
                    // difference captured as two's complement
                    nxt_samp = analog_i.pos - analog_i.neg;
                    nxt_daisy = ~msel;
                    nxt_conn = 1'b0;
                    nxt_pwr = 1'b1;
                    nxt_cyc = CYC_RST;
                    // pseudo-random length keeps conversions varying; the
                    // state lasts len+1 cycles, hence the one taken off here
                    nxt_len = CYC_CNT_W'(CONV_MIN_CYC - 1) +
                        CYC_CNT_W'(lfsr_ff % 8'(CONV_SPAN_CYC + 1));
                    nxt_lfsr = {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
                end
            end
            SARCP_CONV: begin
                nxt_cyc = cyc_ff + 8'h01;
                if (cyc_ff >= len_ff) begin
                    nxt_state = SARCP_ACQ;
                    nxt_conn = 1'b1;
                    nxt_pwr = 1'b0;
                end
            end
            default: nxt_state = SARCP_ACQ;
        endcase
        // registered copy so the busy output comes from a flop
        nxt_conv = (nxt_state == SARCP_CONV);
    end

    always_ff @(posedge clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            state_ff <= SARCP_ACQ;
            cyc_ff <= CYC_RST;
            len_ff <= CYC_RST;
            lfsr_ff <= LFSR_SEED;
            samp_ff <= RES_RST;
            daisy_ff <= 1'b0;
            conn_ff <= 1'b1;
            pwr_ff <= 1'b0;
            conv_ff <= 1'b0;
        end else begin
            conv_ff <= nxt_conv;
            state_ff <= nxt_state;
            cyc_ff <= nxt_cyc;
            len_ff <= nxt_len;
            lfsr_ff <= nxt_lfsr;
            samp_ff <= nxt_samp;
            daisy_ff <= nxt_daisy;
            conn_ff <= nxt_conn;
            pwr_ff <= nxt_pwr;
        end
    end

    // readout: load at select, shift on sclk falls, float after 16 bits
    always_comb begin
        nxt_sh = sh_ff;
        nxt_bit = bit_ff;
        nxt_oe = oe_ff;
        nxt_do = do_ff;
        if (state_ff == SARCP_CONV || trig_rise) begin
            nxt_oe = 1'b0; // conversion start forces float
            nxt_bit = 5'h00;
        end else if (!daisy_ff && ((trig_fall && msel) || (msel_fall && !trig))
                     && bit_ff == 5'h00) begin
            // select edge: 3-wire uses trigger with mode_sel high, 4-wire uses
            // mode_sel once the trigger is already low
            nxt_oe = 1'b1;
            nxt_do = samp_ff[RES_W-1];
            nxt_sh = {samp_ff[RES_W-2:0], 1'b0};
            nxt_bit = 5'h01;
        end else if (!daisy_ff && oe_ff && (trig_rise || msel_rise)) begin
            nxt_oe = 1'b0;
        end else if (oe_ff && sclk_fall) begin
            if (bit_ff == LAST_BIT) begin
                nxt_oe = 1'b0;
            end else begin
                nxt_do = sh_ff[RES_W-1];
                nxt_sh = {sh_ff[RES_W-2:0], daisy_ff ? msel : 1'b0};
                nxt_bit = bit_ff + 5'h01;
            end
        end else if (daisy_ff && bit_ff == 5'h00 && state_ff == SARCP_ACQ && !pwr_ff
                     && !trig) begin
            // daisy chain drives as soon as the trigger drops in acquisition
            nxt_oe = 1'b1;
            nxt_do = samp_ff[RES_W-1];
            nxt_sh = {samp_ff[RES_W-2:0], 1'b0};
            nxt_bit = 5'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            sh_ff <= RES_RST;
            bit_ff <= 5'h00;
            oe_ff <= 1'b0;
            do_ff <= 1'b0;
        end else begin
            sh_ff <= nxt_sh;
            bit_ff <= nxt_bit;
            oe_ff <= nxt_oe;
            do_ff <= nxt_do;
        end
    end

    assign sdo_o = do_ff;
    assign sdo_oe_o = oe_ff;
    assign inputs_conn_o = conn_ff;
    assign powered_o = pwr_ff;
    assign converting_o = conv_ff;
    assign daisy_mode_o = daisy_ff;

    // the host-side timing ..is trusted, not checked

    AST_INPUTS_OPEN: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        state_ff == SARCP_CONV |-> !conn_ff) else $error("inputs connected in conversion");
    AST_CONV_MAX: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        $rose(state_ff == SARCP_CONV) |-> ##[50:130] state_ff == SARCP_ACQ)
        else $error("conversion length out of bounds");
    AST_CONV_MIN: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        $rose(state_ff == SARCP_CONV) |-> (state_ff == SARCP_CONV) [*8])
        else $error("conversion too short");
    AST_CONV_MIN_LEN: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        state_ff == SARCP_CONV && nxt_state == SARCP_ACQ |->
        cyc_ff >= CYC_CNT_W'(CONV_MIN_CYC - 1)) else $error("conversion below minimum");
    AST_PWR_DOWN: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        $fell(state_ff == SARCP_CONV) |-> !pwr_ff && conn_ff)
        else $error("no power down after conversion");
    AST_NO_DRIVE_CONV: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        state_ff == SARCP_CONV |=> !oe_ff || $rose(state_ff == SARCP_ACQ))
        else $error("output driven during conversion");
    AST_MODE_LATCH: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        state_ff == SARCP_ACQ && trig_rise |=> daisy_ff == !$past(msel))
        else $error("mode not latched");
    AST_MSB_FIRST: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        $rose(oe_ff) |-> do_ff == samp_ff[RES_W-1]) else $error("msb not first");
    AST_FLOAT_LAST: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        oe_ff && sclk_fall && bit_ff == LAST_BIT |=> !oe_ff)
        else $error("no float after last bit");
    AST_SHIFT: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        oe_ff && sclk_fall && bit_ff < LAST_BIT && !trig_rise && !msel_rise |=>
        do_ff == $past(sh_ff[RES_W-1])) else $error("shift wrong");
    AST_MODE_USE: assert property (@(posedge clk_i) disable iff (!rst_b_ff)
        state_ff == SARCP_ACQ && !daisy_ff && oe_ff && msel_rise && !trig_rise |=> !oe_ff)
        else $error("deselect ignored");

    COV_CONV: cover property (@(posedge clk_i) $fell(state_ff == SARCP_CONV));
    COV_READ: cover property (@(posedge clk_i) oe_ff && bit_ff == LAST_BIT && sclk_fall);
    COV_DAISY: cover property (@(posedge clk_i) daisy_ff && oe_ff);
endmodule

// ### testbench/sarcp_host_model.sv
// host-side model of the conversion port: drives trigger, select, sclk
// assumes one caller at a time; every pin change follows a clk_i edge
module sarcp_host_model (
    // clock
    input wire logic clk_i,
    // serial output of the port
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    // host pins
    output sarcp_pkg::sarcp_host_pins_t pins_o
);
    import sarcp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic last_ff = 1'b0;
    logic line;
    initial pins_o = '0;
    // a floated line shows the inverse of its last level, never a stale copy
    always @(posedge clk_i) begin
        if (sdo_oe_i) begin
            last_ff <= sdo_i;
        end
    end
    assign line = sdo_oe_i ? sdo_i : ~last_ff;
    // trigger and select move together, held until the next call
    task automatic drive(input logic trig, input logic sel);
        @(posedge clk_i);
        pins_o.conv_trig <= trig;
        pins_o.mode_sel <= sel;
    endtask
    // one sclk period of 140 ns; sample just before the fall, sclk idles low
    task automatic shift(input logic din, output logic bit_o);
        @(posedge clk_i);
        pins_o.sclk <= 1'b1;
        pins_o.mode_sel <= din;
        repeat (6) @(posedge clk_i);
        bit_o = line;
        pins_o.sclk <= 1'b0;
        repeat (7) @(posedge clk_i);
    endtask
endmodule

// ### testbench/sarcp_port_tb.sv
// self-checking bench for the sar conversion port
// assumes the host model owns all pins; the bench owns the analog inputs
module sarcp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sarcp_pkg::*;
    localparam int LIMIT = 6000;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    sarcp_host_pins_t pins;
    sarcp_analog_t analog = '0;
    logic sdo, sdo_oe, conn, pwr, conv, daisy;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    // 100 MHz core clock
    initial forever #5 clk_i = ~clk_i;
    sarcp_port sarcp_port_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .pins_i(pins),
        .analog_i(analog), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .inputs_conn_o(conn),
        .powered_o(pwr), .converting_o(conv), .daisy_mode_o(daisy));
    sarcp_host_model sarcp_host_model_inst (.clk_i(clk_i), .sdo_i(sdo),
        .sdo_oe_i(sdo_oe), .pins_o(pins));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            end_of_test();
        end
    end
    // step past an edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_conv(input logic lvl, output int n);
        n = 0;
        while (conv !== lvl && n < 200) begin
            cyc(1);
            n++;
        end
    endtask
    // start a conversion; inputs are disturbed once sampling is done
    task automatic convert(input logic sel, input logic drop);
        int n;
        sarcp_host_model_inst.drive(1'b1, sel);
        wait_conv(1'b1, n);
        check("conv start", 16'(n <= 6), 16'h0001);
        @(posedge clk_i);
        analog <= ~analog;
        cyc(1);
        check("inputs off", 16'(conn), 16'h0000);
        check("powered", 16'(pwr), 16'h0001);
        if (drop) sarcp_host_model_inst.drive(1'b0, sel);
        wait_conv(1'b0, n);
        check("conv len", 16'(n >= CONV_MIN_CYC - 4 && n <= CONV_MAX_CYC), 16'h0001);
        cyc(3);
        check("inputs on", 16'(conn), 16'h0001);
        check("powered down", 16'(pwr), 16'h0000);
        check("daisy mode", 16'(daisy), 16'(!sel));
    endtask
    task automatic read(input int nbits, input logic [15:0] din, output logic [15:0] w);
        logic b;
        w = '0;
        for (int i = 0; i < nbits; i++) begin
            sarcp_host_model_inst.shift(din[15-i], b);
            w = {w[14:0], b};
        end
    endtask
    // load inputs at an edge, then convert with the given mode_sel, dropping the trigger mid-conversion if asked
    task automatic setup(input logic [31:0] a, input logic sel, input logic drop);
        @(posedge clk_i);
        analog <= a;
        convert(sel, drop);
    endtask
    task automatic t_three_wire;
        logic [15:0] w;
        setup(32'hFF00_0234, 1'b1, 1'b0);
        sarcp_host_model_inst.drive(1'b0, 1'b1);
        cyc(5);
        check("oe select", 16'(sdo_oe), 16'h0001);
        read(16, 16'hFFFF, w);
        check("word", w, 16'hFCCC);
        cyc(5);
        check("oe after 16", 16'(sdo_oe), 16'h0000);
        $display("test three_wire done");
    endtask
    task automatic t_four_wire;
        logic [15:0] w;
        setup(32'h1234_0000, 1'b1, 1'b1);
        check("oe trig low", 16'(sdo_oe), 16'h0000);
        sarcp_host_model_inst.drive(1'b0, 1'b0);
        cyc(5);
        check("oe select", 16'(sdo_oe), 16'h0001);
        read(4, 16'h0000, w);
        check("nibble", w, 16'h0001);
        sarcp_host_model_inst.drive(1'b0, 1'b1);
        cyc(5);
        check("oe deselect", 16'(sdo_oe), 16'h0000);
        $display("test four_wire done");
    endtask
    task automatic t_daisy;
        logic [15:0] w;
        setup(32'h0000_7FFF, 1'b0, 1'b0);
        sarcp_host_model_inst.drive(1'b0, 1'b0);
        cyc(5);
        read(16, 16'hA5C3, w);
        check("daisy word", w, 16'h8001);
        $display("test daisy done");
    endtask
    task automatic t_abort;
        logic [15:0] w;
        setup(32'h5100_0100, 1'b1, 1'b0);
        sarcp_host_model_inst.drive(1'b0, 1'b1);
        cyc(5);
        read(4, 16'hFFFF, w);
        check("nibble", w, 16'h0005);
        sarcp_host_model_inst.drive(1'b1, 1'b1);
        cyc(5);
        check("oe on trig", 16'(sdo_oe), 16'h0000);
        cyc(150);
        $display("test abort done");
    endtask
    // reset for five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        cyc(6);
        check("idle oe", 16'(sdo_oe), 16'h0000);
        t_three_wire();
        t_four_wire();
        t_daisy();
        t_abort();
        end_of_test();
    end
endmodule
